//--- smls_top.sv
// Top of the servo function-selection logic: parameters, mode, limits, display and baud
// ----------------------------------------------------------------
// Notes on behaviour
// - Mode code 0..5 means P, S, T, P/S, P/T, S/T; default 0.
// - Composite mode with shift input open runs the first mode of the pair.
// - Composite mode with shift input shorted runs the second mode.
// - Restart-applied parameters take a new value only after control power restart.
// - Display code 0..13 picks the start-up display item; default 0.
// - Source 0 takes CCW and CW limits from the two analog inputs.
// - Source 1 or 2 takes limits from the CCW and CW limit parameters.
// - Torque mode limits both directions with the CCW limit parameter.
// - Baud code 0..3, default 3, applied after restart.
// - Parameter numbers 00..0F form the function-selection group.
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module smls_top #(
  parameter int TL_W            = 12,
  parameter int SHIFT_QUIET_CYC = smls_pkg::SHIFT_QUIET_CYC
) (
  input  wire logic            SYS_CLK,
  input  wire logic            SYS_RST,
  input  wire logic            PARAM_WR,
  input  wire logic [7:0]      PARAM_ADDR,
  input  wire logic [7:0]      PARAM_WDATA,
  input  wire logic            POWER_RESTART,
  input  wire logic            MODE_SHIFT_OPEN,
  input  wire logic [TL_W-1:0] CCW_ANALOG_LIMIT_INPUT,
  input  wire logic [TL_W-1:0] CW_ANALOG_LIMIT_INPUT,
  output logic [7:0]           PARAM_RDATA,
  output logic                 PARAM_WR_ERR,
  output logic                 PARAM_FUNC_SEL,
  output logic [2:0]           ACTIVE_MODE,
  output logic                 SHIFT_SETTLING,
  output logic [3:0]           STARTUP_DISPLAY,
  output logic [1:0]           SERIAL_BAUD_CODE,
  output logic [TL_W-1:0]      CCW_TORQUE_LIMIT,
  output logic [TL_W-1:0]      CW_TORQUE_LIMIT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int CNT_W = $clog2(SHIFT_QUIET_CYC + 1);

  smls_pkg::smls_wr_t  wr_req;
  smls_pkg::smls_cfg_t stored_cfg;
  smls_pkg::smls_cfg_t active_cfg;
  smls_pkg::smls_run_t run_mode;
  logic                wr_ok;
  logic [TL_W-1:0]     ccw_limit;
  logic [TL_W-1:0]     cw_limit;
  logic [2:0]          shift_sync_reg;
  logic                shift_open_reg;
  logic [CNT_W-1:0]    quiet_cnt_reg;
  logic [2:0]          mode_reg;
  logic [3:0]          disp_reg;
  logic [1:0]          baud_reg;
  logic [TL_W-1:0]     ccw_lim_reg;
  logic [TL_W-1:0]     cw_lim_reg;
  logic [7:0]          rdata_reg;
  logic                wr_err_reg;

  assign wr_req = '{addr: PARAM_ADDR, data: PARAM_WDATA};

  // ----------------------------------------------------------------
  // Parameter store
  // ----------------------------------------------------------------
  smls_param_file u_param_file (
    .clk        (SYS_CLK),
    .rst        (SYS_RST),
    .wr_en      (PARAM_WR),
    .wr         (wr_req),
    .restart    (POWER_RESTART),
    .wr_ok      (wr_ok),
    .stored_cfg (stored_cfg),
    .active_cfg (active_cfg)
  );

  // ----------------------------------------------------------------
  // Mode shift input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      shift_sync_reg <= 3'h7;
    end else begin
      shift_sync_reg <= {shift_sync_reg[1:0], MODE_SHIFT_OPEN};
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      shift_open_reg <= 1'b1;
    end else if (shift_sync_reg[1] == shift_sync_reg[2]) begin
      shift_open_reg <= shift_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // Quiet window after a mode shift
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      quiet_cnt_reg <= '0;
    end else if (shift_sync_reg[1] == shift_sync_reg[2] && shift_sync_reg[2] != shift_open_reg) begin
      quiet_cnt_reg <= CNT_W'(SHIFT_QUIET_CYC);
    end else if (quiet_cnt_reg != '0) begin
      quiet_cnt_reg <= quiet_cnt_reg - CNT_W'(1);
    end
  end

  assign SHIFT_SETTLING = (quiet_cnt_reg != '0);

  // ----------------------------------------------------------------
  // Mode and torque limit selection
  // ----------------------------------------------------------------
  smls_mode_sel #(
    .TL_W (TL_W)
  ) u_mode_sel (
    .mode_code  (active_cfg.mode),
    .shift_open (shift_open_reg),
    .tl_src     (active_cfg.tl_src),
    .ccw_val    (active_cfg.ccw_val),
    .cw_val     (active_cfg.cw_val),
    .ccw_analog (CCW_ANALOG_LIMIT_INPUT),
    .cw_analog  (CW_ANALOG_LIMIT_INPUT),
    .run_mode   (run_mode),
    .ccw_limit  (ccw_limit),
    .cw_limit   (cw_limit)
  );

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode_reg <= smls_pkg::RUN_POSITION;
    end else begin
      mode_reg <= run_mode;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ccw_lim_reg <= '0;
      cw_lim_reg  <= '0;
    end else begin
      ccw_lim_reg <= ccw_limit;
      cw_lim_reg  <= cw_limit;
    end
  end

  // ----------------------------------------------------------------
  // Display and baud codes
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      disp_reg <= smls_pkg::RST_DISP_SEL[3:0];
      baud_reg <= smls_pkg::RST_BAUD_SEL[1:0];
    end else begin
      disp_reg <= active_cfg.disp[3:0];
      baud_reg <= active_cfg.baud[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Read-back and write status
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_reg <= '0;
    end else begin
      case (PARAM_ADDR)
        smls_pkg::ADDR_DISP_SEL:   rdata_reg <= stored_cfg.disp;
        smls_pkg::ADDR_MODE_SEL:   rdata_reg <= stored_cfg.mode;
        smls_pkg::ADDR_TL_SRC:     rdata_reg <= stored_cfg.tl_src;
        smls_pkg::ADDR_BAUD_SEL:   rdata_reg <= stored_cfg.baud;
        smls_pkg::ADDR_CCW_TL_VAL: rdata_reg <= stored_cfg.ccw_val;
        smls_pkg::ADDR_CW_TL_VAL:  rdata_reg <= stored_cfg.cw_val;
        default:                   rdata_reg <= '0;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_err_reg <= 1'b0;
    end else begin
      wr_err_reg <= PARAM_WR && !wr_ok;
    end
  end

  assign PARAM_FUNC_SEL   = (PARAM_ADDR[7:4] == smls_pkg::FUNC_SEL_GROUP);
  assign PARAM_RDATA      = rdata_reg;
  assign PARAM_WR_ERR     = wr_err_reg;
  assign ACTIVE_MODE      = mode_reg;
  assign STARTUP_DISPLAY  = disp_reg;
  assign SERIAL_BAUD_CODE = baud_reg;
  assign CCW_TORQUE_LIMIT = ccw_lim_reg;
  assign CW_TORQUE_LIMIT  = cw_lim_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_mode_single;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (active_cfg.mode == smls_pkg::MODE_S) |=> (ACTIVE_MODE == smls_pkg::RUN_SPEED);
  endproperty
  a_mode_single: assert property (p_mode_single) else $error("Speed code not decoded");

  property p_shift_first;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (active_cfg.mode == smls_pkg::MODE_PT && shift_open_reg)
        |=> (ACTIVE_MODE == smls_pkg::RUN_POSITION);
  endproperty
  a_shift_first: assert property (p_shift_first) else $error("Open shift not first mode");

  property p_shift_second;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (active_cfg.mode == smls_pkg::MODE_ST && !shift_open_reg)
        |=> (ACTIVE_MODE == smls_pkg::RUN_TORQUE);
  endproperty
  a_shift_second: assert property (p_shift_second) else $error("Shorted shift not second");

  property p_restart_hold;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (wr_ok && PARAM_ADDR == smls_pkg::ADDR_MODE_SEL && !POWER_RESTART)
        |=> $stable(active_cfg.mode);
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("Mode applied before restart");

  property p_restart_apply;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (POWER_RESTART && !PARAM_WR) |=> ##1 (STARTUP_DISPLAY == $past(stored_cfg.disp[3:0], 2));
  endproperty
  a_restart_apply: assert property (p_restart_apply) else $error("Display not applied");

  property p_tl_analog;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (active_cfg.tl_src == smls_pkg::TL_SRC_ANALOG && run_mode != smls_pkg::RUN_TORQUE)
        |=> (CW_TORQUE_LIMIT == $past(CW_ANALOG_LIMIT_INPUT));
  endproperty
  a_tl_analog: assert property (p_tl_analog) else $error("CW limit not from analog");

  property p_tl_param;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (active_cfg.tl_src != smls_pkg::TL_SRC_ANALOG && run_mode != smls_pkg::RUN_TORQUE)
        |=> (CW_TORQUE_LIMIT == TL_W'($past(active_cfg.cw_val)));
  endproperty
  a_tl_param: assert property (p_tl_param) else $error("CW limit not from parameter");

  property p_tl_torque;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (ACTIVE_MODE == smls_pkg::RUN_TORQUE) |-> (CW_TORQUE_LIMIT == CCW_TORQUE_LIMIT);
  endproperty
  a_tl_torque: assert property (p_tl_torque) else $error("Torque mode limits differ");

  property p_baud_range;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (active_cfg.baud <= smls_pkg::MAX_BAUD_SEL) && (stored_cfg.mode <= smls_pkg::MAX_MODE_SEL);
  endproperty
  a_baud_range: assert property (p_baud_range) else $error("Stored code out of range");

  property p_func_group;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (PARAM_ADDR == smls_pkg::ADDR_BAUD_SEL) |-> PARAM_FUNC_SEL;
  endproperty
  a_func_group: assert property (p_func_group) else $error("Baud not in function group");

  property p_reject;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (PARAM_WR && PARAM_ADDR == smls_pkg::ADDR_DISP_SEL && PARAM_WDATA > smls_pkg::MAX_DISP_SEL)
        |=> (PARAM_WR_ERR && $stable(stored_cfg.disp));
  endproperty
  a_reject: assert property (p_reject) else $error("Bad display value taken");

  property p_settle_start;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (shift_open_reg != $past(shift_open_reg)) |-> SHIFT_SETTLING;
  endproperty
  a_settle_start: assert property (p_settle_start) else $error("No settling after shift");

  property p_baud_apply;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (POWER_RESTART && !PARAM_WR) |=> ##1 (SERIAL_BAUD_CODE == $past(stored_cfg.baud[1:0], 2));
  endproperty
  a_baud_apply: assert property (p_baud_apply) else $error("Baud not applied");

  property p_readback;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (PARAM_ADDR == smls_pkg::ADDR_MODE_SEL) |=> (PARAM_RDATA == $past(stored_cfg.mode));
  endproperty
  a_readback: assert property (p_readback) else $error("Mode read-back wrong");

  property p_reserved_reject;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (PARAM_WR && PARAM_ADDR == smls_pkg::ADDR_MAKER_RSVD) |=> PARAM_WR_ERR;
  endproperty
  a_reserved_reject: assert property (p_reserved_reject) else $error("Reserved write taken");

endmodule // smls_top
`default_nettype wire

//--- smls_pkg.sv
// Shared constants, types and parameter map for the servo mode and limit selection block
package smls_pkg;

  // ----------------------------------------------------------------
  // Parameter addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MAKER_RSVD   = 8'h00;
  localparam logic [7:0] ADDR_DISP_SEL     = 8'h01;
  localparam logic [7:0] ADDR_MODE_SEL     = 8'h02;
  localparam logic [7:0] ADDR_TL_SRC       = 8'h03;
  localparam logic [7:0] ADDR_OT_MODE      = 8'h04;
  localparam logic [7:0] ADDR_SPD_SRC      = 8'h05;
  localparam logic [7:0] ADDR_ZCLAMP_MODE  = 8'h06;
  localparam logic [7:0] ADDR_SPD_MON      = 8'h07;
  localparam logic [7:0] ADDR_TRQ_MON      = 8'h08;
  localparam logic [7:0] ADDR_TL_OUT_SEL   = 8'h09;
  localparam logic [7:0] ADDR_ZSPD_OUT_SEL = 8'h0a;
  localparam logic [7:0] ADDR_BAUD_SEL     = 8'h0c;
  localparam logic [7:0] ADDR_CCW_TL_VAL   = 8'h5e;
  localparam logic [7:0] ADDR_CW_TL_VAL    = 8'h5f;
  localparam logic [3:0] FUNC_SEL_GROUP    = 4'h0;

  // ----------------------------------------------------------------
  // Values after reset and range limits
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DISP_SEL  = 8'h00;
  localparam logic [7:0] RST_MODE_SEL  = 8'h00;
  localparam logic [7:0] RST_TL_SRC    = 8'h01;
  localparam logic [7:0] RST_BAUD_SEL  = 8'h03;
  localparam logic [7:0] RST_TL_VAL    = 8'hff;
  localparam logic [7:0] MAX_DISP_SEL  = 8'h0d;
  localparam logic [7:0] MAX_MODE_SEL  = 8'h05;
  localparam logic [7:0] MAX_BAUD_SEL  = 8'h03;

  // ----------------------------------------------------------------
  // Control mode codes and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_P  = 8'h00;
  localparam logic [7:0] MODE_S  = 8'h01;
  localparam logic [7:0] MODE_T  = 8'h02;
  localparam logic [7:0] MODE_PS = 8'h03;
  localparam logic [7:0] MODE_PT = 8'h04;
  localparam logic [7:0] MODE_ST = 8'h05;
  localparam logic [7:0] TL_SRC_ANALOG = 8'h00;
  localparam int CLK_HZ          = 50_000_000;
  localparam int SHIFT_QUIET_MS  = 10;
  localparam int SHIFT_QUIET_CYC = SHIFT_QUIET_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    RUN_POSITION = 3'b001,
    RUN_SPEED    = 3'b010,
    RUN_TORQUE   = 3'b100
  } smls_run_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } smls_wr_t;

  typedef struct packed {
    logic [7:0] disp;
    logic [7:0] mode;
    logic [7:0] tl_src;
    logic [7:0] baud;
    logic [7:0] ccw_val;
    logic [7:0] cw_val;
  } smls_cfg_t;

endpackage

//--- smls_param_file.sv
// Parameter store with range check and restart-applied shadow values
`timescale 1ns/10ps
`default_nettype none
module smls_param_file (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              wr_en,
  input  wire smls_pkg::smls_wr_t wr,
  input  wire logic              restart,
  output logic                   wr_ok,
  output smls_pkg::smls_cfg_t    stored_cfg,
  output smls_pkg::smls_cfg_t    active_cfg
);

  // ----------------------------------------------------------------
  // Range and reset tables
  // ----------------------------------------------------------------
  function automatic logic [8:0] max_of(input logic [7:0] a);
    case (a)
      smls_pkg::ADDR_DISP_SEL:     max_of = {1'b1, smls_pkg::MAX_DISP_SEL};
      smls_pkg::ADDR_MODE_SEL:     max_of = {1'b1, smls_pkg::MAX_MODE_SEL};
      smls_pkg::ADDR_TL_SRC:       max_of = 9'h102;
      smls_pkg::ADDR_OT_MODE:      max_of = 9'h102;
      smls_pkg::ADDR_SPD_SRC:      max_of = 9'h103;
      smls_pkg::ADDR_ZCLAMP_MODE:  max_of = 9'h102;
      smls_pkg::ADDR_SPD_MON:      max_of = 9'h109;
      smls_pkg::ADDR_TRQ_MON:      max_of = 9'h107;
      smls_pkg::ADDR_TL_OUT_SEL:   max_of = 9'h104;
      smls_pkg::ADDR_ZSPD_OUT_SEL: max_of = 9'h104;
      smls_pkg::ADDR_BAUD_SEL:     max_of = {1'b1, smls_pkg::MAX_BAUD_SEL};
      smls_pkg::ADDR_CCW_TL_VAL:   max_of = 9'h1ff;
      smls_pkg::ADDR_CW_TL_VAL:    max_of = 9'h1ff;
      default:                     max_of = 9'h000;
    endcase
  endfunction

  function automatic logic [7:0] rst_of(input logic [3:0] a);
    case (a)
      4'h3, 4'h4, 4'ha: rst_of = 8'h01;
      4'h7, 4'hc:       rst_of = 8'h03;
      default:          rst_of = 8'h00;
    endcase
  endfunction

  function automatic logic restart_applied(input logic [3:0] a);
    restart_applied = (a == 4'h0) || (a == 4'h1) || (a == 4'h2) || (a == 4'h4) || (a == 4'hc);
  endfunction

  logic [7:0] stored_mem [0:15];
  logic [7:0] active_mem [0:15];
  logic [7:0] ccw_val_reg;
  logic [7:0] cw_val_reg;
  logic [8:0] lim;

  assign lim   = max_of(wr.addr);
  assign wr_ok = wr_en && lim[8] && (wr.data <= lim[7:0]);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        stored_mem[i] <= rst_of(4'(i));
        active_mem[i] <= rst_of(4'(i));
      end
      ccw_val_reg <= smls_pkg::RST_TL_VAL;
      cw_val_reg  <= smls_pkg::RST_TL_VAL;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (wr_ok && wr.addr == 8'(i)) begin
          stored_mem[i] <= wr.data;
          if (!restart_applied(4'(i))) begin
            active_mem[i] <= wr.data;
          end
        end else if (restart) begin
          active_mem[i] <= stored_mem[i];
        end
      end
      if (wr_ok && wr.addr == smls_pkg::ADDR_CCW_TL_VAL) begin
        ccw_val_reg <= wr.data;
      end
      if (wr_ok && wr.addr == smls_pkg::ADDR_CW_TL_VAL) begin
        cw_val_reg <= wr.data;
      end
    end
  end

  assign stored_cfg = '{disp: stored_mem[1], mode: stored_mem[2], tl_src: stored_mem[3],
                        baud: stored_mem[12], ccw_val: ccw_val_reg, cw_val: cw_val_reg};
  assign active_cfg = '{disp: active_mem[1], mode: active_mem[2], tl_src: active_mem[3],
                        baud: active_mem[12], ccw_val: ccw_val_reg, cw_val: cw_val_reg};

endmodule // smls_param_file
`default_nettype wire

//--- smls_mode_sel.sv
// Control mode decode and torque limit source selection
`timescale 1ns/10ps
`default_nettype none
module smls_mode_sel #(
  parameter int TL_W = 12
) (
  input  wire logic [7:0]      mode_code,
  input  wire logic            shift_open,
  input  wire logic [7:0]      tl_src,
  input  wire logic [7:0]      ccw_val,
  input  wire logic [7:0]      cw_val,
  input  wire logic [TL_W-1:0] ccw_analog,
  input  wire logic [TL_W-1:0] cw_analog,
  output smls_pkg::smls_run_t  run_mode,
  output logic [TL_W-1:0]      ccw_limit,
  output logic [TL_W-1:0]      cw_limit
);

  function automatic logic [TL_W-1:0] widen(input logic [7:0] v);
    widen = TL_W'(v);
  endfunction

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    case (mode_code)
      smls_pkg::MODE_P:  run_mode = smls_pkg::RUN_POSITION;
      smls_pkg::MODE_S:  run_mode = smls_pkg::RUN_SPEED;
      smls_pkg::MODE_T:  run_mode = smls_pkg::RUN_TORQUE;
      smls_pkg::MODE_PS: run_mode = shift_open ? smls_pkg::RUN_POSITION : smls_pkg::RUN_SPEED;
      smls_pkg::MODE_PT: run_mode = shift_open ? smls_pkg::RUN_POSITION : smls_pkg::RUN_TORQUE;
      smls_pkg::MODE_ST: run_mode = shift_open ? smls_pkg::RUN_SPEED : smls_pkg::RUN_TORQUE;
      default:           run_mode = smls_pkg::RUN_POSITION;
    endcase
  end

  // ----------------------------------------------------------------
  // Torque limit source
  // ----------------------------------------------------------------
  always_comb begin
    if (run_mode == smls_pkg::RUN_TORQUE) begin
      ccw_limit = widen(ccw_val);
      cw_limit  = widen(ccw_val);
    end else if (tl_src == smls_pkg::TL_SRC_ANALOG) begin
      ccw_limit = ccw_analog;
      cw_limit  = cw_analog;
    end else begin
      ccw_limit = widen(ccw_val);
      cw_limit  = widen(cw_val);
    end
  end

endmodule // smls_mode_sel
`default_nettype wire

//--- smls_host_model.sv
// Host controller model driving the mode-shift pin and analog limit commands
`timescale 1ns/10ps
`default_nettype none
module smls_host_model #(
  parameter int Q = 20
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        shift_tgt,
  input  wire logic [11:0] ccw_tgt,
  input  wire logic [11:0] cw_tgt,
  output logic             shift_open,
  output logic [11:0]      ccw_an,
  output logic [11:0]      cw_an,
  output logic             idle
);
  int quiet;
  assign idle = (quiet > Q) && (shift_open == shift_tgt) && (ccw_an == ccw_tgt)
              && (cw_an == cw_tgt);
  // Any shift or command restarts the quiet count, so none comes near a shift
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet      <= 0;
      shift_open <= 1'b1;
      ccw_an     <= 12'h000;
      cw_an      <= 12'h000;
    end else if (quiet <= Q) begin
      quiet <= quiet + 1;
    end else if (shift_open != shift_tgt) begin
      shift_open <= shift_tgt;
      quiet      <= 0;
    end else if ((ccw_an != ccw_tgt) || (cw_an != cw_tgt)) begin
      ccw_an <= ccw_tgt;
      cw_an  <= cw_tgt;
      quiet  <= 0;
    end
  end
endmodule // smls_host_model
`default_nettype wire

//--- tb.sv
// Self-checking testbench for the servo mode and limit selection block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end
module tb;
  localparam int Q = 20;
  typedef struct { int sel; logic [11:0] v; } smls_note_t;
  logic clk, rst, wr, restart, shift_tgt, shift_open, idle, wr_err, func_sel, settling;
  logic [7:0] addr, wdata, rdata;
  logic [11:0] ccw_tgt, cw_tgt, ccw_an, cw_an, ccw_lim, cw_lim;
  logic [2:0] act_mode;
  logic [3:0] disp;
  logic [1:0] baud;
  int bad_count, check_count, cycles;
  smls_note_t notes[$];
  smls_note_t e;
  event smp;
  logic [7:0] ra[6] = '{8'h01, 8'h02, 8'h03, 8'h0c, 8'h5e, 8'h5f};
  logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h01, 8'h03, 8'hff, 8'hff};
  logic [7:0] pa[3] = '{8'h01, 8'h02, 8'h0c};
  logic [7:0] pm[3] = '{8'd13, 8'd5, 8'd3};
  logic [7:0] ua[4] = '{8'h00, 8'h0b, 8'h0d, 8'h60};
  logic [2:0] m1[6] = '{3'h1, 3'h2, 3'h4, 3'h1, 3'h1, 3'h2};
  logic [2:0] m2[6] = '{3'h1, 3'h2, 3'h4, 3'h2, 3'h4, 3'h4};
  logic [7:0] v, c, w;

  smls_top #(.TL_W(12), .SHIFT_QUIET_CYC(Q)) i_dut (.SYS_CLK(clk), .SYS_RST(rst),
    .PARAM_WR(wr), .PARAM_ADDR(addr), .PARAM_WDATA(wdata), .POWER_RESTART(restart),
    .MODE_SHIFT_OPEN(shift_open), .CCW_ANALOG_LIMIT_INPUT(ccw_an),
    .CW_ANALOG_LIMIT_INPUT(cw_an), .PARAM_RDATA(rdata), .PARAM_WR_ERR(wr_err),
    .PARAM_FUNC_SEL(func_sel), .ACTIVE_MODE(act_mode), .SHIFT_SETTLING(settling),
    .STARTUP_DISPLAY(disp), .SERIAL_BAUD_CODE(baud), .CCW_TORQUE_LIMIT(ccw_lim),
    .CW_TORQUE_LIMIT(cw_lim));
  smls_host_model #(.Q(Q)) i_host (.clk(clk), .rst(rst), .shift_tgt(shift_tgt),
    .ccw_tgt(ccw_tgt), .cw_tgt(cw_tgt), .shift_open(shift_open), .ccw_an(ccw_an),
    .cw_an(cw_an), .idle(idle));

  function automatic logic [11:0] obs(input int s);
    case (s)
      0: return {4'h0, rdata};
      1: return {11'h000, wr_err};
      2: return {11'h000, func_sel};
      3: return {9'h000, act_mode};
      4: return {8'h00, disp};
      5: return {10'h000, baud};
      6: return ccw_lim;
      8: return {11'h000, settling};
      default: return cw_lim;
    endcase
  endfunction
  task automatic note(input int s, input logic [11:0] x);
    notes.push_back('{s, x});
  endtask
  task automatic fire();
    -> smp;
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    wr = 1'b1;
    addr = a;
    wdata = d;
    tick(1);
    wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    addr = a;
    tick(2);
  endtask
  task automatic power_cycle();
    tick(1);
    restart = 1'b1;
    tick(1);
    restart = 1'b0;
    tick(3);
  endtask
  task automatic settle();
    for (int i = 0; i < 200 && idle !== 1'b1; i++) tick(1);
    tick(6);
  endtask
  task automatic end_test(input string name);
    $display("Test %s done", name);
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and result watcher
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      finish_test();
    end
  end
  always @(smp) begin
    while (notes.size() > 0) begin
      e = notes.pop_front();
      `CHK(obs(e.sel), e.v)
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {wr, restart, addr, wdata} = '0;
    shift_tgt = 1'b1;
    ccw_tgt = 12'h000;
    cw_tgt = 12'h000;
    void'($urandom(32'h80a40e13));
    tick(4);
    rst = 1'b0;
    tick(2);
    note(3, 12'h001);
    note(4, 12'h000);
    note(5, 12'h003);
    note(6, 12'h0ff);
    note(7, 12'h0ff);
    fire();
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      note(0, {4'h0, rv[i]});
      fire();
    end
    for (int a = 0; a < 17; a++) begin
      addr = (a == 16) ? 8'h5e : a[7:0];
      tick(1);
      note(2, {11'h000, a < 16});
      fire();
    end
    end_test("reset_and_group");
    for (int i = 0; i < 4; i++) begin
      write(ua[i], 8'h00);
      note(1, 12'h001);
      fire();
    end
    for (int i = 0; i < 3; i++) begin
      write(pa[i], pm[i] + 8'd1 + 8'($urandom % 240));
      note(1, 12'h001);
      fire();
      v = 8'($urandom % (pm[i] + 1));
      write(pa[i], v);
      note(1, 12'h000);
      fire();
      rd(pa[i]);
      note(0, {4'h0, v});
      note(i == 0 ? 4 : (i == 1 ? 3 : 5), i == 1 ? 12'h001 : rv[i + i / 2]);
      fire();
      power_cycle();
      note(i == 0 ? 4 : (i == 1 ? 3 : 5), i == 1 ? {9'h000, m1[v]} : {4'h0, v});
      fire();
    end
    end_test("range_and_restart");
    for (int m = 0; m < 6; m++) begin
      write(8'h02, m[7:0]);
      power_cycle();
      shift_tgt = 1'b1;
      settle();
      note(3, {9'h000, m1[m]});
      fire();
      shift_tgt = 1'b0;
      tick(10);
      note(8, 12'h001);
      fire();
      settle();
      note(3, {9'h000, m2[m]});
      note(8, 12'h000);
      fire();
    end
    end_test("control_modes");
    for (int s = 0; s < 3; s++) begin
      c = 8'($urandom);
      w = 8'($urandom);
      write(8'h5e, c);
      write(8'h5f, w);
      write(8'h03, s[7:0]);
      ccw_tgt = 12'($urandom);
      cw_tgt = 12'($urandom);
      shift_tgt = 1'b0;
      settle();
      note(6, {4'h0, c});
      note(7, {4'h0, c});
      fire();
      shift_tgt = 1'b1;
      settle();
      note(6, s == 0 ? ccw_tgt : {4'h0, c});
      note(7, s == 0 ? cw_tgt : {4'h0, w});
      fire();
    end
    write(8'h03, 8'h01);
    tick(2);
    note(6, {4'h0, c});
    note(7, {4'h0, w});
    fire();
    end_test("torque_limits");
    finish_test();
  end
endmodule // tb
`default_nettype wire
